/* File: tpc_pkg.sv */
// package for the transmit/receive port and clock output configuration block
package tpc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] TPC_ADDR_TX_SET  = 8'h07;
    localparam logic [7:0] TPC_ADDR_RX_SET  = 8'h08;
    localparam logic [7:0] TPC_ADDR_DIE_REV = 8'h0F;

    // transmit settings fields
    localparam int TPC_TX_FMT_BIT  = 0;
    localparam int TPC_TX_EDGE_BIT = 1;
    localparam int TPC_INTERP_LSB  = 4;
    localparam logic [7:0] TPC_TX_MASK = 8'hF3;

    // receive / clock output fields
    localparam int TPC_RX_FMT_BIT   = 0;
    localparam int TPC_RX_EDGE_BIT  = 1;
    localparam int TPC_RX_TRI_BIT   = 3;
    localparam int TPC_CKA_DIS_BIT  = 4;
    localparam int TPC_CKB_DIS_BIT  = 5;
    localparam int TPC_CKA_OSC_BIT  = 6;
    localparam int TPC_CKB_QTR_BIT  = 7;
    localparam logic [7:0] TPC_RX_MASK = 8'hFB;

    // reset values
    localparam logic [7:0] TPC_TX_RST = 8'h10;
    localparam logic [7:0] TPC_RX_RST = 8'h00;
    localparam logic [1:0] TPC_PLL_RST = 2'h0;

    // interpolation codes
    localparam logic [3:0] TPC_INTERP_LPF    = 4'h1;
    localparam logic [3:0] TPC_INTERP_BYPASS = 4'h2;
    localparam logic [3:0] TPC_INTERP_BPF    = 4'h5;

    // data word width and sign bit
    localparam int TPC_DW = 10;
    localparam logic [9:0] TPC_SIGN = 10'h200;

    // pll multiplier codes: factors 1, 2, 4, 8
    localparam logic [1:0] TPC_PLL_X1 = 2'h0;
    localparam logic [1:0] TPC_PLL_X2 = 2'h1;
    localparam logic [1:0] TPC_PLL_X4 = 2'h2;
    localparam logic [1:0] TPC_PLL_X8 = 2'h3;

    // die revision: arbitrary neutral value
    localparam logic [7:0] TPC_DIE_REV_DEF = 8'h01;

    typedef enum logic [3:0] {
        TPC_FILT_LPF    = 4'b0001,
        TPC_FILT_BYPASS = 4'b0010,
        TPC_FILT_BPF    = 4'b0100,
        TPC_FILT_OFF    = 4'b1000
    } tpc_filt_t;

    // register write request
    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tpc_wr_t;

    // receive port bundle
    typedef struct packed {
        logic [9:0] data;
        logic [9:0] oen_n;
    } tpc_rx_bus_t;

endpackage

/* File: tpc_port_cfg.sv */
// port configuration and auxiliary clock outputs of the modem front end
module tpc_port_cfg (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rstn,
    // register access, already decoded from the serial port
    input  wire tpc_pkg::tpc_wr_t     wr,
    input  wire logic [7:0]           rd_addr,
    output logic [7:0]                rd_data,
    // pll multiplier code from the clock source register
    input  wire logic [1:0]           pll_code,
    // oscillator and port clocks, asynchronous pins
    input  wire logic                 oscillator_input,
    input  wire logic                 transmit_port_clock,
    input  wire logic                 receive_port_clock,
    // transmit data pins
    input  wire logic [9:0]           tx_pin,
    output logic [9:0]                tx_word,
    output logic                      tx_word_valid,
    output logic                      tx_read_stb,
    output logic                      tx_interp_2x,
    output tpc_pkg::tpc_filt_t        tx_filter,
    // receive data from the converter and to the pins
    input  wire logic [9:0]           adc_word,
    output tpc_pkg::tpc_rx_bus_t      rx_bus,
    // auxiliary clock outputs
    output logic                      aux_clock_a,
    output logic                      second_aux_clock_alt
);
    import tpc_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] tx_set_q;
    logic [7:0] rx_set_q;
    logic [1:0] pll_q;

    // settings writes; undefined bits masked away
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_set_q <= TPC_TX_RST;
            rx_set_q <= TPC_RX_RST;
        end else if (wr.we) begin
            if (wr.addr == TPC_ADDR_TX_SET) begin
                tx_set_q <= wr.wdata & TPC_TX_MASK;
            end
            if (wr.addr == TPC_ADDR_RX_SET) begin
                rx_set_q <= wr.wdata & TPC_RX_MASK;
            end
        end
    end

    // pll code is a quasi-static setting from another register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pll_q <= TPC_PLL_RST;
        end else begin
            pll_q <= pll_code;
        end
    end

    // read mux; die revision has no write path at all
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= 8'h00;
        end else begin
            unique case (rd_addr)
                TPC_ADDR_TX_SET:  rd_data <= tx_set_q;
                TPC_ADDR_RX_SET:  rd_data <= rx_set_q;
                TPC_ADDR_DIE_REV: rd_data <= TPC_DIE_REV_DEF;
                default:          rd_data <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] s1_q, s2_q, s3_q;
    logic [2:0] pins;
    assign pins = {oscillator_input, receive_port_clock,
                   transmit_port_clock};

    // first stage read only by the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
            s3_q <= 3'h0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    logic [2:0] rise, fall;
    assign rise = s2_q & ~s3_q;
    assign fall = ~s2_q & s3_q;

    logic [9:0] txp1_q, txp2_q;
    // data pins pass two flops too, aligned with the clock sync path
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txp1_q <= 10'h000;
            txp2_q <= 10'h000;
        end else begin
            txp1_q <= tx_pin;
            txp2_q <= txp1_q;
        end
    end

    // ------------------------------------------------------------
    // transmit capture
    // ------------------------------------------------------------
    logic tx_edge;
    assign tx_edge = tx_set_q[TPC_TX_EDGE_BIT] ? fall[0] : rise[0];

    // straight binary is turned into twos complement by flipping the msb
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_word       <= 10'h000;
            tx_word_valid <= 1'b0;
        end else begin
            tx_word_valid <= tx_edge;
            if (tx_edge) begin
                tx_word <= tx_set_q[TPC_TX_FMT_BIT] ? txp2_q
                                                    : txp2_q ^ TPC_SIGN;
            end
        end
    end

    // filter decode; unknown codes select TPC_FILT_OFF while tx_interp_2x stays high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_filter    <= TPC_FILT_LPF;
            tx_interp_2x <= 1'b1;
        end else begin
            unique case (tx_set_q[TPC_INTERP_LSB +: 4])
                TPC_INTERP_LPF:    tx_filter <= TPC_FILT_LPF;
                TPC_INTERP_BYPASS: tx_filter <= TPC_FILT_BYPASS;
                TPC_INTERP_BPF:    tx_filter <= TPC_FILT_BPF;
                default:           tx_filter <= TPC_FILT_OFF;
            endcase
            tx_interp_2x <= tx_set_q[TPC_INTERP_LSB +: 4] != TPC_INTERP_BYPASS;
        end
    end

    // ------------------------------------------------------------
    // oscillator times L: L strobes per oscillator period
    // ------------------------------------------------------------
    logic [7:0] osc_per_q, osc_cnt_q;
    logic [7:0] step;
    logic [7:0] mul_acc_q;
    logic       mul_stb;
    logic [3:0] lfac;

    always_comb begin
        unique case (pll_q)
            TPC_PLL_X1: lfac = 4'h1;
            TPC_PLL_X2: lfac = 4'h2;
            TPC_PLL_X4: lfac = 4'h4;
            TPC_PLL_X8: lfac = 4'h8;
        endcase
    end

    // measure the oscillator period in system cycles
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            osc_cnt_q <= 8'h00;
            osc_per_q <= 8'h01;
        end else if (rise[2]) begin
            osc_per_q <= (osc_cnt_q == 8'h00) ? 8'h01 : osc_cnt_q;
            osc_cnt_q <= 8'h01;
        end else if (osc_cnt_q != 8'hFF) begin
            osc_cnt_q <= osc_cnt_q + 8'h01;
        end
    end

    // fractional accumulator; rate is capped at the system clock
    // sum is one bit wider so a large step cannot wrap the compare
    logic [8:0] mul_sum;
    assign step    = {4'h0, lfac};
    assign mul_sum = {1'b0, mul_acc_q} + {1'b0, step};
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mul_acc_q <= 8'h00;
            mul_stb   <= 1'b0;
        end else if (mul_sum >= {1'b0, osc_per_q}) begin
            mul_acc_q <= 8'(mul_sum - {1'b0, osc_per_q});
            mul_stb   <= 1'b1;
        end else begin
            mul_acc_q <= 8'(mul_sum);
            mul_stb   <= 1'b0;
        end
    end

    // aux clock a needs two toggles per output period, so it runs its
    // own accumulator at twice the multiplied rate; caps at half clk
    logic [8:0] ck_sum;
    logic [7:0] ck_acc_q;
    logic       ck_stb;
    assign ck_sum = {1'b0, ck_acc_q} + {4'h0, lfac, 1'b0};
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ck_acc_q <= 8'h00;
            ck_stb   <= 1'b0;
        end else if (ck_sum >= {1'b0, osc_per_q}) begin
            ck_acc_q <= 8'(ck_sum - {1'b0, osc_per_q});
            ck_stb   <= 1'b1;
        end else begin
            ck_acc_q <= 8'(ck_sum);
            ck_stb   <= 1'b0;
        end
    end

    // buffer read strobe: every multiplied tick, or every second one
    logic half_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            half_q      <= 1'b0;
            tx_read_stb <= 1'b0;
        end else begin
            if (mul_stb) begin
                half_q <= ~half_q;
            end
            tx_read_stb <= mul_stb & (~tx_interp_2x | half_q);
        end
    end

    // ------------------------------------------------------------
    // receive port
    // ------------------------------------------------------------
    logic rx_edge;
    assign rx_edge = rx_set_q[TPC_RX_EDGE_BIT] ? fall[1] : rise[1];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_bus.data  <= 10'h000;
            rx_bus.oen_n <= 10'h3FF;
        end else begin
            if (rx_edge) begin
                rx_bus.data <= rx_set_q[TPC_RX_FMT_BIT] ? adc_word ^ TPC_SIGN
                                                        : adc_word;
            end
            rx_bus.oen_n <= {10{rx_set_q[TPC_RX_TRI_BIT]}};
        end
    end

    // ------------------------------------------------------------
    // auxiliary clocks
    // ------------------------------------------------------------
    logic [1:0] osc_div_q;
    logic       mtog_q;

    // divide the oscillator by two and four on its sampled rising edges
    // counting both edges would give osc and osc/2 instead
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            osc_div_q <= 2'h0;
            mtog_q    <= 1'b0;
        end else begin
            if (rise[2]) begin
                osc_div_q <= osc_div_q + 2'h1;
            end
            if (ck_stb) begin
                mtog_q <= ~mtog_q;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aux_clock_a          <= 1'b0;
            second_aux_clock_alt <= 1'b0;
        end else begin
            if (rx_set_q[TPC_CKA_DIS_BIT]) begin
                aux_clock_a <= 1'b0;
            end else begin
                aux_clock_a <= rx_set_q[TPC_CKA_OSC_BIT] ? s3_q[2]
                                                         : mtog_q;
            end
            if (rx_set_q[TPC_CKB_DIS_BIT]) begin
                second_aux_clock_alt <= 1'b0;
            end else begin
                second_aux_clock_alt <= rx_set_q[TPC_CKB_QTR_BIT]
                                        ? osc_div_q[1]
                                        : osc_div_q[0];
            end
        end
    end

endmodule

/* File: tpc_port_cfg_sva.sv */
// assertion checker for the port configuration block
module tpc_port_cfg_sva (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 rstn,
    // register access
    input wire tpc_pkg::tpc_wr_t     wr,
    input wire logic [7:0]           rd_addr,
    input wire logic [7:0]           rd_data,
    // watched outputs
    input wire logic                 tx_word_valid,
    input wire logic                 tx_interp_2x,
    input wire tpc_pkg::tpc_filt_t   tx_filter,
    input wire tpc_pkg::tpc_rx_bus_t rx_bus,
    input wire logic                 aux_clock_a,
    input wire logic                 second_aux_clock_alt
);
    timeunit 1ns;
    timeprecision 1ps;
    import tpc_pkg::*;
    logic [7:0] rx_q;
    // shadow of the receive settings; outputs lag it, hence the repeats
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            rx_q <= TPC_RX_RST;
        else if (wr.we && wr.addr == TPC_ADDR_RX_SET)
            rx_q <= wr.wdata;
    end
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_die_rev_ro: assert property (
        rd_addr == TPC_ADDR_DIE_REV |=> rd_data == TPC_DIE_REV_DEF)
        else $error("die revision changed");
    a_tx_gaps: assert property (
        rd_addr == TPC_ADDR_TX_SET |=> rd_data[3:2] == 2'h0)
        else $error("tx undefined bits set");
    a_rx_gaps: assert property (
        rd_addr == TPC_ADDR_RX_SET |=> rd_data[2] == 1'b0)
        else $error("rx undefined bit set");
    a_bypass_rate: assert property (
        tx_interp_2x == (tx_filter != TPC_FILT_BYPASS))
        else $error("interp rate and filter disagree");
    a_cka_off: assert property (
        rx_q[TPC_CKA_DIS_BIT] [*4] |-> !aux_clock_a)
        else $error("first aux clock not held low");
    a_ckb_off: assert property (
        rx_q[TPC_CKB_DIS_BIT] [*4] |-> !second_aux_clock_alt)
        else $error("second aux clock not held low");
    a_rx_float: assert property (
        rx_q[TPC_RX_TRI_BIT] [*3] |-> rx_bus.oen_n == 10'h3FF)
        else $error("rx lines driven while floated");
    a_valid_pulse: assert property (
        $rose(tx_word_valid) |=> !tx_word_valid)
        else $error("tx valid longer than one cycle");
    cover property (tx_word_valid);
    cover property (rx_q[TPC_CKA_DIS_BIT] [*4]);
    cover property (tx_filter == TPC_FILT_BPF);
endmodule

/* File: tpc_mac_model.sv */
// modem controller model driving the transmit port and port clocks
module tpc_mac_model (
    // pacing clock
    input  wire logic clk,
    // port pins
    output logic [9:0] tx_pin,
    output logic       transmit_port_clock,
    output logic       receive_port_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    // port clocks stand still low between frames
    initial begin
        tx_pin = 10'h000;
        transmit_port_clock = 1'b0;
        receive_port_clock = 1'b0;
    end
    // one 80 ns port clock; words move mid-phase so each edge sees one
    task automatic frame(input logic [9:0] rw, input logic [9:0] fw);
        @(posedge clk);
        tx_pin <= rw;
        repeat (2) @(posedge clk);
        transmit_port_clock <= 1'b1;
        receive_port_clock <= 1'b1;
        repeat (2) @(posedge clk);
        tx_pin <= fw;
        repeat (2) @(posedge clk);
        transmit_port_clock <= 1'b0;
        receive_port_clock <= 1'b0;
        repeat (2) @(posedge clk);
        tx_pin <= ~fw; // released lines must not keep the last word
    endtask
endmodule

/* File: tb.sv */
// testbench for the port configuration block
`define CHK(g, e) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("mismatch at %0t: got %h exp %h", $time, g, e); \
    end \
end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tpc_pkg::*;
    logic clk, rstn, osc, tpc, rpc, t2x, cka, ckb, vld, stb;
    logic [2:0] osc_cnt;
    logic [1:0] pll_code;
    logic [7:0] rd_addr, rd_data;
    logic [9:0] tx_pin, tx_word, adc_word;
    tpc_wr_t wr;
    tpc_filt_t filt;
    tpc_rx_bus_t rx_bus;
    int bad_count = 0;
    int n_checks = 0;
    tpc_mac_model mac (.clk(clk), .tx_pin(tx_pin),
        .transmit_port_clock(tpc), .receive_port_clock(rpc));
    tpc_port_cfg DUT (.clk(clk), .rstn(rstn), .wr(wr), .rd_addr(rd_addr),
        .rd_data(rd_data), .pll_code(pll_code), .oscillator_input(osc),
        .transmit_port_clock(tpc), .receive_port_clock(rpc),
        .tx_pin(tx_pin), .tx_word(tx_word), .tx_word_valid(vld),
        .tx_read_stb(stb), .tx_interp_2x(t2x), .tx_filter(filt),
        .adc_word(adc_word), .rx_bus(rx_bus), .aux_clock_a(cka),
        .second_aux_clock_alt(ckb));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // oscillator pin with a 160 ns period
    always @(posedge clk) begin
        osc_cnt <= osc_cnt + 3'h1;
        if (osc_cnt == 3'h7)
            osc <= ~osc;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= '{we: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        wr.we <= 1'b0;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_addr <= a;
        @(posedge clk);
        #1;
        `CHK(rd_data, e);
    endtask
    function automatic logic near(input int n, input int e);
        return (n >= e - 2) && (n <= e + 2);
    endfunction
    // counts strobes and aux clock rises after the rates settle
    task automatic count(output int s, output int a, output int b);
        logic pa, pb;
        s = 0;
        a = 0;
        b = 0;
        repeat (64) @(posedge clk);
        pa = cka;
        pb = ckb;
        repeat (320) begin
            @(posedge clk);
            #1;
            s += int'(stb);
            a += int'(cka && !pa);
            b += int'(ckb && !pb);
            pa = cka;
            pb = ckb;
        end
    endtask
    task automatic t_regs();
        chk_rd(TPC_ADDR_TX_SET, TPC_TX_RST);
        chk_rd(TPC_ADDR_RX_SET, TPC_RX_RST);
        wr_reg(TPC_ADDR_TX_SET, 8'hFF);
        wr_reg(TPC_ADDR_RX_SET, 8'hFF);
        wr_reg(TPC_ADDR_DIE_REV, 8'hA5);
        wr_reg(8'h20, 8'h00); // unmapped: must touch nothing
        chk_rd(TPC_ADDR_TX_SET, 8'hF3);
        chk_rd(TPC_ADDR_RX_SET, 8'hFB);
        chk_rd(TPC_ADDR_DIE_REV, TPC_DIE_REV_DEF);
        $display("t_regs done");
    endtask
    task automatic t_tx();
        logic [9:0] rw, fw, p;
        for (int i = 0; i < 4; i++) begin
            rw = 10'h155 + 10'(i);
            fw = 10'h2A8 + 10'(i);
            p = i[1] ? fw : rw;
            wr_reg(TPC_ADDR_TX_SET, {4'h1, 2'h0, i[1], i[0]});
            mac.frame(rw, fw);
            repeat (6) @(posedge clk);
            #1;
            `CHK(tx_word, i[0] ? p : p ^ TPC_SIGN);
        end
        $display("t_tx done");
    endtask
    task automatic t_rx();
        logic [9:0] w, e;
        for (int i = 0; i < 4; i++) begin
            w = 10'h0C3 + 10'(i);
            e = (i[0] ^ i[1]) ? ~w : w;
            @(posedge clk);
            adc_word <= w;
            wr_reg(TPC_ADDR_RX_SET, {4'h0, i[1], 1'b0, i[0] ^ i[1], i[0]});
            // converter word changes in the same cycle as the falling port clock edge
            fork
                mac.frame(10'h000, 10'h3FF);
                begin
                    repeat (7) @(posedge clk);
                    adc_word <= ~w;
                end
            join
            repeat (6) @(posedge clk);
            #1;
            `CHK(rx_bus.oen_n, i[1] ? 10'h3FF : 10'h000);
            if (i[1] == 0)
                `CHK(rx_bus.data, i[0] ? e ^ TPC_SIGN : e);
        end
        $display("t_rx done");
    endtask
    task automatic t_rates();
        int s, a, b;
        logic [3:0] cd [4] = '{4'h2, 4'h1, 4'h5, 4'h1};
        int es [4] = '{20, 20, 40, 80};
        tpc_filt_t ef [4] = '{TPC_FILT_BYPASS, TPC_FILT_LPF,
                              TPC_FILT_BPF, TPC_FILT_LPF};
        wr_reg(TPC_ADDR_RX_SET, 8'h00);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            pll_code <= 2'(i);
            wr_reg(TPC_ADDR_TX_SET, {cd[i], 4'h0});
            count(s, a, b);
            `CHK(filt, ef[i]);
            `CHK(t2x, cd[i] != 4'h2);
            `CHK(near(s, es[i]), 1'b1);
            `CHK(near(a, 20 << i), 1'b1);
            `CHK(near(b, 10), 1'b1);
        end
        $display("t_rates done");
    endtask
    task automatic t_aux();
        int s, a, b;
        logic [7:0] rv [4] = '{8'h00, 8'h40, 8'h80, 8'h30};
        int ea [4] = '{40, 20, 40, 0};
        int eb [4] = '{10, 10, 5, 0};
        @(posedge clk);
        pll_code <= 2'h1;
        for (int i = 0; i < 4; i++) begin
            wr_reg(TPC_ADDR_RX_SET, rv[i]);
            count(s, a, b);
            `CHK(near(a, ea[i]), 1'b1);
            `CHK(near(b, eb[i]), 1'b1);
        end
        `CHK({cka, ckb}, 2'b00);
        $display("t_aux done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        wr = '0;
        rd_addr = 8'h00;
        pll_code = 2'h0;
        adc_word = 10'h000;
        osc = 1'b0;
        osc_cnt = 3'h0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_tx();
        t_rx();
        t_rates();
        t_aux();
        wrap_up();
    end
endmodule
bind tpc_port_cfg tpc_port_cfg_sva u_sva (.*);
